// ===== shared/scd_consts.svh
// constants for the serial latched column driver
`ifndef SCD_CONSTS_SVH
`define SCD_CONSTS_SVH
`define SCD_CHANNELS     32
`define SCD_SYNC_STAGES  2
`define SCD_DEAD_NS      80
`define SCD_CLK_NS       40
// dead time rounded up to whole cycles, at least one
`define SCD_DEAD_CYC     ((`SCD_DEAD_NS + `SCD_CLK_NS - 1) / `SCD_CLK_NS)
`define SCD_LATCH_RESET  32'h0000_0000
`endif

// ===== shared/scd_pkg.sv
// types shared by the column driver files
package scd_pkg;
    typedef enum logic [1:0] {
        SCD_DRV_LOW,
        SCD_DRV_GAP,
        SCD_DRV_HIGH
    } scd_drv_state_t;
endpackage

// ===== src/scd_out_stage.sv
// one totem-pole output stage with break-before-make sequencing
`timescale 1ns/10ps
`default_nettype none
`include "scd_consts.svh"
module scd_out_stage #(
    parameter int DEAD_CYC = `SCD_DEAD_CYC
) (
    input  wire logic mclk_i,
    input  wire logic srst_i,
    input  wire logic want_high_i,
    output logic      src_on_o,
    output logic      snk_on_o
);
    import scd_pkg::*;

    scd_drv_state_t state_reg;
    scd_drv_state_t state_next;
    logic [7:0]     gap_cnt_reg;
    logic [7:0]     gap_cnt_next;
    wire            gap_done;

    assign gap_done = (gap_cnt_reg == 8'(DEAD_CYC - 1));

    // both transitions pass through the gap so source and sink never overlap
    always_comb begin
        state_next   = state_reg;
        gap_cnt_next = 8'h00;
        unique case (state_reg)
            SCD_DRV_LOW: begin
                if (want_high_i) begin
                    state_next = SCD_DRV_GAP;
                end
            end
            SCD_DRV_GAP: begin
                gap_cnt_next = gap_cnt_reg + 8'h01;
                if (gap_done) begin
                    gap_cnt_next = 8'h00;
                    state_next   = want_high_i ? SCD_DRV_HIGH : SCD_DRV_LOW;
                end
            end
            SCD_DRV_HIGH: begin
                if (!want_high_i) begin
                    state_next = SCD_DRV_GAP;
                end
            end
        endcase
    end

    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            state_reg   <= SCD_DRV_LOW;
            gap_cnt_reg <= 8'h00;
        end else begin
            state_reg   <= state_next;
            gap_cnt_reg <= gap_cnt_next;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            src_on_o <= 1'b0;
            snk_on_o <= 1'b1;
        end else begin
            src_on_o <= (state_next == SCD_DRV_HIGH);
            snk_on_o <= (state_next == SCD_DRV_LOW);
        end
    end

    no_overlap_a: assert property (@(posedge mclk_i) disable iff (srst_i)
        !(src_on_o && snk_on_o))
        else $error("source and sink on together");

    sink_after_gap_a: assert property (@(posedge mclk_i) disable iff (srst_i)
        $fell(src_on_o) |-> !snk_on_o)
        else $error("sink turned on with source release");
endmodule
`default_nettype wire

// ===== src/scd_column_driver.sv
// serial-input latched column driver: shift register, latches, gated outputs
`timescale 1ns/10ps
`default_nettype none
`include "scd_consts.svh"
// How it works
// - a 32-stage shift register feeds 32 latches, each gated to one column
// - with output enable high each column shows its latch
// - serial out carries the last stage so devices can be chained
// - serial out depends on the shift register only, not strobe or enable
// - source drive turns off before sink drive turns on
// - each rising shift clock edge moves data in at stage one
// - strobe high copies register to latches; strobe low holds them
module scd_column_driver #(
    parameter int CHANNELS = `SCD_CHANNELS,
    parameter int DEAD_CYC = `SCD_DEAD_CYC
) (
    input  wire logic                mclk_i,
    input  wire logic                srst_i,
    input  wire logic                sclk_i,
    input  wire logic                sdata_i,
    input  wire logic                strobe_i,
    input  wire logic                oe_i,
    output logic                     sdata_o,
    output logic [CHANNELS-1:0]      col_o,
    output logic [CHANNELS-1:0]      src_on_o,
    output logic [CHANNELS-1:0]      snk_on_o
);
    import scd_pkg::*;

    // two-stage synchronisers; the first stage feeds only the second
    logic [3:0]          meta_reg;
    logic [3:0]          sync_reg;
    logic                sclk_prev_reg;
    logic [CHANNELS-1:0] shift_reg;
    logic [CHANNELS-1:0] shift_next;
    logic [CHANNELS-1:0] latch_reg;
    logic [CHANNELS-1:0] latch_next;
    logic [CHANNELS-1:0] col_next;
    wire                 sclk_s;
    wire                 sdata_s;
    wire                 strobe_s;
    wire                 oe_s;
    wire                 sclk_rise;
    // cycles since enable went low, saturating, used by the settle check
    logic [7:0]          oe_low_cnt_reg;
    logic [7:0]          oe_low_cnt_next;

    // one step of the chain: the new bit enters stage one, stage 32 leaves
    function automatic logic [CHANNELS-1:0] shift_in(input logic [CHANNELS-1:0] cur,
                                                     input logic                bit_in);
        return {cur[CHANNELS-2:0], bit_in};
    endfunction

    // gate one line of latches with the enable; disabled columns sink
    function automatic logic [CHANNELS-1:0] gate_cols(input logic                en,
                                                      input logic [CHANNELS-1:0] lat);
        return en ? lat : '0;
    endfunction

    assign sclk_s    = sync_reg[0];
    assign sdata_s   = sync_reg[1];
    assign strobe_s  = sync_reg[2];
    assign oe_s      = sync_reg[3];
    assign sclk_rise = sclk_s && !sclk_prev_reg;

    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            meta_reg      <= 4'h0;
            sync_reg      <= 4'h0;
            sclk_prev_reg <= 1'b0;
        end else begin
            meta_reg      <= {oe_i, strobe_i, sdata_i, sclk_i};
            sync_reg      <= meta_reg;
            sclk_prev_reg <= sclk_s;
        end
    end

    // data sampled together with the clock edge keeps the controller's setup margin
    assign shift_next = sclk_rise ? shift_in(shift_reg, sdata_s)
                                  : shift_reg;
    // transparent while strobe is high, so a shift during strobe passes through
    assign latch_next = strobe_s ? shift_reg : latch_reg;
    assign col_next   = gate_cols(oe_s, latch_reg);

    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            shift_reg <= CHANNELS'(`SCD_LATCH_RESET);
            latch_reg <= CHANNELS'(`SCD_LATCH_RESET);
            col_o     <= CHANNELS'(`SCD_LATCH_RESET);
            sdata_o   <= 1'b0;
        end else begin
            shift_reg <= shift_next;
            latch_reg <= latch_next;
            col_o     <= col_next;
            sdata_o   <= shift_next[CHANNELS-1];
        end
    end

    // saturates so a long blank period never wraps back into the settle window
    assign oe_low_cnt_next = oe_s ? 8'h00
                           : (oe_low_cnt_reg == 8'hFF) ? oe_low_cnt_reg
                           : oe_low_cnt_reg + 8'h01;

    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            oe_low_cnt_reg <= 8'h00;
        end else begin
            oe_low_cnt_reg <= oe_low_cnt_next;
        end
    end

    genvar g;
    generate
        for (g = 0; g < CHANNELS; g++) begin : g_out
            scd_out_stage #(
                .DEAD_CYC (DEAD_CYC)
            ) u_stage (
                .mclk_i      (mclk_i),
                .srst_i      (srst_i),
                .want_high_i (col_o[g]),
                .src_on_o    (src_on_o[g]),
                .snk_on_o    (snk_on_o[g])
            );

            // per-channel checks: drives against the column value and each other, column against enable and latch
            chan_src_a: assert property (@(posedge mclk_i) disable iff (srst_i)
                src_on_o[g] |-> (col_o[g] || $past(col_o[g])))
                else $error("source on for a low column");

            chan_snk_a: assert property (@(posedge mclk_i) disable iff (srst_i)
                snk_on_o[g] |-> (!col_o[g] || !$past(col_o[g])))
                else $error("sink on for a high column");

            chan_snk_rise_a: assert property (@(posedge mclk_i) disable iff (srst_i)
                $rose(snk_on_o[g]) |-> $past(!src_on_o[g]))
                else $error("sink turned on while source was on");

            chan_src_rise_a: assert property (@(posedge mclk_i) disable iff (srst_i)
                $rose(src_on_o[g]) |-> $past(!snk_on_o[g]))
                else $error("source turned on while sink was on");

            chan_col_a: assert property (@(posedge mclk_i) disable iff (srst_i)
                col_o[g] |-> $past(oe_s && latch_reg[g]))
                else $error("column high without enable and latch");
        end
    endgenerate

    shift_advance_a: assert property (@(posedge mclk_i) disable iff (srst_i)
        sclk_rise |=> (shift_reg == {$past(shift_reg[CHANNELS-2:0]), $past(sdata_s)}))
        else $error("shift register did not advance on clock edge");

    shift_hold_a: assert property (@(posedge mclk_i) disable iff (srst_i)
        !sclk_rise |=> $stable(shift_reg))
        else $error("shift register moved without clock edge");

    latch_load_a: assert property (@(posedge mclk_i) disable iff (srst_i)
        strobe_s |=> (latch_reg == $past(shift_reg)))
        else $error("latches missed strobe load");

    latch_hold_a: assert property (@(posedge mclk_i) disable iff (srst_i)
        !strobe_s |=> $stable(latch_reg))
        else $error("latches changed with strobe low");

    col_enabled_a: assert property (@(posedge mclk_i) disable iff (srst_i)
        oe_s |=> (col_o == $past(latch_reg)))
        else $error("enabled columns do not show latches");

    col_disabled_a: assert property (@(posedge mclk_i) disable iff (srst_i)
        !oe_s |=> (col_o == '0))
        else $error("disabled columns not low");

    cascade_out_a: assert property (@(posedge mclk_i) disable iff (srst_i)
        1'b1 |=> (sdata_o == shift_reg[CHANNELS-1]))
        else $error("serial out not last stage");

    cascade_quiet_a: assert property (@(posedge mclk_i) disable iff (srst_i)
        !sclk_rise ##1 !sclk_rise |=> $stable(sdata_o))
        else $error("serial out moved without a shift");

    // reset is checked without the disable so the cleared state is seen
    reset_state_a: assert property (@(posedge mclk_i)
        srst_i |=> (col_o == '0 && src_on_o == '0 && snk_on_o == '1 && !sdata_o))
        else $error("outputs not cleared by reset");

    cascade_strobe_a: assert property (@(posedge mclk_i) disable iff (srst_i)
        (strobe_s && !sclk_rise) |=> $stable(sdata_o))
        else $error("serial out moved with strobe");

    cascade_enable_a: assert property (@(posedge mclk_i) disable iff (srst_i)
        (!oe_s && !sclk_rise) |=> $stable(sdata_o))
        else $error("serial out moved with enable low");

    cascade_sample_a: assert property (@(posedge mclk_i) disable iff (srst_i)
        sclk_rise |=> (sdata_o == $past(shift_reg[CHANNELS-2])))
        else $error("serial out skipped a stage");

    latch_source_a: assert property (@(posedge mclk_i) disable iff (srst_i)
        $changed(latch_reg) |-> $past(strobe_s))
        else $error("latches changed without strobe");

    col_steady_a: assert property (@(posedge mclk_i) disable iff (srst_i)
        ($past(oe_s) && $past(oe_s, 2) && $past(!strobe_s, 2)) |-> $stable(col_o))
        else $error("columns moved while enabled and held");

    // after the dead time every stage must have settled to sinking
    oe_settle_a: assert property (@(posedge mclk_i) disable iff (srst_i)
        (oe_low_cnt_reg > 8'(DEAD_CYC + 3)) |-> (snk_on_o == '1 && src_on_o == '0))
        else $error("columns not sinking after enable low");
endmodule
`default_nettype wire

// ===== bench/scd_ctrl_model.sv
// display controller model: serial link, strobe and enable
`timescale 1ns/10ps
`default_nettype none
module scd_ctrl_model (
    input  wire logic mclk_i,
    output logic      sclk_o,
    output logic      sdata_o,
    output logic      strobe_o,
    output logic      oe_o
);
    initial begin
        sclk_o = 1'b0;
        sdata_o = 1'b0;
        strobe_o = 1'b0;
        oe_o = 1'b0;
    end
    // 4 mclk set-up and hold, clock stands low between words
    task automatic send_word(input logic [31:0] w);
        for (int i = 31; i >= 0; i--) begin
            sdata_o = w[i];
            repeat (4) @(posedge mclk_i);
            #1 sclk_o = 1'b1;
            repeat (4) @(posedge mclk_i);
            #1 sclk_o = 1'b0;
        end
        sdata_o = ~w[0];
    endtask
    // strobe only after the whole line is
    task automatic pulse_strobe();
        strobe_o = 1'b1;
        repeat (4) @(posedge mclk_i);
        #1 strobe_o = 1'b0;
    endtask
    task automatic set_oe(input logic v);
        oe_o = v;
    endtask
endmodule
`default_nettype wire

// ===== bench/scd_column_driver_tb.sv
// self-checking bench for the serial latched column driver
`timescale 1ns/10ps
`default_nettype none
module scd_column_driver_tb;
    localparam logic [31:0] W1 = 32'hA5C3_0F81;
    localparam logic [31:0] W2 = 32'h3C5A_F00E;
    logic        mclk_i, srst_i, sclk, sdata, strobe, oe, sdata_o;
    logic [31:0] col_o, src_on_o, snk_on_o;
    int          failures;
    int          n_checks;
    int          cycles;
    scd_ctrl_model u_ctrl (.mclk_i(mclk_i), .sclk_o(sclk), .sdata_o(sdata),
        .strobe_o(strobe), .oe_o(oe));
    scd_column_driver u_dut (.mclk_i(mclk_i), .srst_i(srst_i), .sclk_i(sclk),
        .sdata_i(sdata), .strobe_i(strobe), .oe_i(oe), .sdata_o(sdata_o),
        .col_o(col_o), .src_on_o(src_on_o), .snk_on_o(snk_on_o));
    initial begin
        mclk_i = 1'b0;
        forever #20 mclk_i = ~mclk_i;
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] %0t ns seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic close_out();
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // ceiling well above the roughly 580 cycles the run needs
    always @(posedge mclk_i) begin
        cycles++;
        if (cycles == 5000) begin
            failures++;
            close_out();
        end
    end
    always @(negedge mclk_i)
        if (srst_i === 1'b0) check(src_on_o & snk_on_o, 32'h0000_0000);
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge mclk_i);
        #1;
    endtask
    task automatic t_reset_values();
        check(col_o, 32'h0000_0000);
        check(src_on_o, 32'h0000_0000);
        check(snk_on_o, 32'hFFFF_FFFF);
        check(sdata_o, 32'h0000_0000);
    endtask
    task automatic t_load_line();
        u_ctrl.set_oe(1'b1);
        u_ctrl.send_word(W1);
        u_ctrl.pulse_strobe();
        wait_cyc(10);
        check(col_o, W1);
        check(src_on_o, W1);
        check(snk_on_o, ~W1);
        check(sdata_o, W1[31]);
    endtask
    // next line shifts in while the latched one stays on the columns
    task automatic t_hold_cascade();
        u_ctrl.send_word(W2);
        wait_cyc(6);
        check(col_o, W1);
        check(sdata_o, W2[31]);
    endtask
    task automatic t_disable();
        u_ctrl.set_oe(1'b0);
        wait_cyc(10);
        check(col_o, 32'h0000_0000);
        check(snk_on_o, 32'hFFFF_FFFF);
        check(src_on_o, 32'h0000_0000);
        check(sdata_o, W2[31]);
        u_ctrl.pulse_strobe();
        wait_cyc(6);
        check(sdata_o, W2[31]);
        check(col_o, 32'h0000_0000);
        u_ctrl.set_oe(1'b1);
        wait_cyc(10);
        check(col_o, W2);
        check(snk_on_o, ~W2);
    endtask
    initial begin
        srst_i = 1'b1;
        wait_cyc(12);
        t_reset_values();
        srst_i = 1'b0;
        wait_cyc(2);
        t_load_line();
        t_hold_cascade();
        t_disable();
        close_out();
    end
endmodule
`default_nettype wire
